// ===== design/eqts_sequencer.sv
// Equalizer tuning sequencer for one transceiver octal.
// Assumes clk is the octal's configuration-port clock and rst is released
// by surrounding logic once the active channels report receiver_ready.
//
// Operation
// - Select 0..7 picks one channel, 8 picks all, other codes illegal.
// - Channel selection is ignored while the tuner is held in reset.
// - Reset returns to the initial state and retunes all channels unlooped.
// - Retune request re-enables tuning for the selected channel or channels.
// - Sticky per-channel done bits: 1 finished cleanly, 0 otherwise.
// - Current state of the tuning machine is shown on a 9-bit output.
// - A 4-bit output names the channel whose status is being read.
// - All logic runs on the configuration-port clock.
// - Block masters the configuration port: address, data, enable, write.
// - Out of reset, coarse and fine tuning enabled regardless of loopback.
// - Machine halts in done and restarts only on a retune pulse.
// - After a retune the channel's done bit sets only on a clean finish and machine returns done.
// - One sequencer per octal, owning that octal's configuration port.
`timescale 1ns/1ns
`default_nettype none

module eqts_sequencer
  import eqts_pkg::*;
#(
  parameter int POLL_CYC = POLL_GAP_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [CH_COUNT-1:0] loopback_en,
  input wire logic [SEL_W-1:0] channel_select,
  input wire logic retune_req,
  output logic [CH_COUNT-1:0] tuning_done,
  output logic [8:0] tuning_state,
  output logic [3:0] status_read_channel,
  output logic [CFG_AW-1:0] cfg_addr,
  output logic [CFG_DW-1:0] cfg_wdata,
  output logic cfg_en,
  output logic cfg_we,
  input wire logic [CFG_DW-1:0] cfg_rdata,
  input wire logic cfg_ready
);

  typedef enum logic [8:0] {
    ST_START,
    ST_EN_REQ,
    ST_EN_WAIT,
    ST_POLL_GAP,
    ST_POLL_REQ,
    ST_POLL_WAIT,
    ST_OFF_REQ,
    ST_OFF_WAIT,
    ST_TUNE_DONE
  } eqts_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Lowest channel in the mask at or above a start index, SEL_NONE if none
  function automatic logic [3:0] eqts_next_ch(
    input logic [CH_COUNT-1:0] m,
    input logic [3:0] from
  );
    logic [3:0] res;
    res = SEL_NONE;
    for (int i = CH_COUNT - 1; i >= 0; i--)
    begin
      if (m[i] && (4'(i) >= from))
      begin
        res = 4'(i);
      end
    end
    return res;
  endfunction : eqts_next_ch

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  eqts_state_t state_r, state_nxt;
  logic [CH_COUNT-1:0] mask_r, mask_nxt;
  logic [CH_IDX_W-1:0] ch_r, ch_nxt;
  logic [POLL_CNT_W-1:0] gap_r, gap_nxt;
  logic [CH_COUNT-1:0] done_r, done_nxt;
  logic [CH_COUNT-1:0] done_set, done_clr;
  logic boot_r, boot_nxt;

  // Access port wiring
  logic req_valid;
  logic req_we;
  logic [CFG_AW-1:0] req_addr;
  logic [CFG_DW-1:0] req_wdata;
  logic rsp_valid;
  logic [CFG_DW-1:0] rsp_rdata;

  // Selection decode
  logic [CH_COUNT-1:0] sel_mask;
  logic sel_legal;
  logic [3:0] first_ch;
  logic [3:0] after_ch;
  logic [CFG_AW-1:0] ch_offset;

  ////////////////////////////////////////////////////////////////////////////
  eqts_chan_decode u_decode (
    .sel(channel_select),
    .mask(sel_mask),
    .legal(sel_legal)
  );

  eqts_cfg_access u_access (
    .clk(clk),
    .rst(rst),
    .req_valid(req_valid),
    .req_we(req_we),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .cfg_en(cfg_en),
    .cfg_we(cfg_we),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .cfg_ready(cfg_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign first_ch = eqts_next_ch(sel_mask, 4'h0);
  assign after_ch = eqts_next_ch(mask_r, 4'({1'b0, ch_r}) + 4'h1);
  assign ch_offset = CFG_AW'({ch_r, {CH_STRIDE_SHIFT{1'b0}}});

  always_comb
  begin
    state_nxt = state_r;
    mask_nxt = mask_r;
    ch_nxt = ch_r;
    gap_nxt = gap_r;
    done_set = '0;
    done_clr = '0;
    req_valid = 1'b0;
    req_we = 1'b0;
    req_addr = '0;
    req_wdata = CTRL_OFF;
    unique case (state_r)
      ST_START:
      begin
        // Reset mask covers every channel, so channel 0 goes first
        ch_nxt = '0;
        state_nxt = ST_EN_REQ;
      end
      ST_EN_REQ:
      begin
        req_valid = 1'b1;
        req_we = 1'b1;
        req_addr = CTRL_BASE + ch_offset;
        req_wdata = CTRL_OFF;
        req_wdata[EN_COARSE_BIT] = 1'b1;
        req_wdata[EN_FINE_BIT] = 1'b1;
        // Loopback is sampled here only; user keeps it steady until done
        req_wdata[LOOPBACK_BIT] = loopback_en[ch_r] & ~boot_r;
        state_nxt = ST_EN_WAIT;
      end
      ST_EN_WAIT:
      begin
        if (rsp_valid)
        begin
          gap_nxt = POLL_CNT_W'(POLL_CYC - 1);
          state_nxt = ST_POLL_GAP;
        end
      end
      ST_POLL_GAP:
      begin
        // Spacing keeps polling from hogging the shared port
        if (gap_r == '0)
        begin
          state_nxt = ST_POLL_REQ;
        end
        else
        begin
          gap_nxt = gap_r - 1'b1;
        end
      end
      ST_POLL_REQ:
      begin
        req_valid = 1'b1;
        req_addr = STAT_BASE + ch_offset;
        state_nxt = ST_POLL_WAIT;
      end
      ST_POLL_WAIT:
      begin
        if (rsp_valid)
        begin
          if (rsp_rdata[STAT_DONE_BIT])
          begin
            // A finish with errors leaves the bit clear
            done_set[ch_r] = ~rsp_rdata[STAT_ERR_BIT];
            state_nxt = ST_OFF_REQ;
          end
          else
          begin
            gap_nxt = POLL_CNT_W'(POLL_CYC - 1);
            state_nxt = ST_POLL_GAP;
          end
        end
      end
      ST_OFF_REQ:
      begin
        req_valid = 1'b1;
        req_we = 1'b1;
        req_addr = CTRL_BASE + ch_offset;
        req_wdata = CTRL_OFF;
        state_nxt = ST_OFF_WAIT;
      end
      ST_OFF_WAIT:
      begin
        if (rsp_valid)
        begin
          if (after_ch == SEL_NONE)
          begin
            state_nxt = ST_TUNE_DONE;
          end
          else
          begin
            ch_nxt = after_ch[CH_IDX_W-1:0];
            state_nxt = ST_EN_REQ;
          end
        end
      end
      ST_TUNE_DONE:
      begin
        // Halts here; illegal codes leave the machine parked
        if (retune_req && sel_legal)
        begin
          mask_nxt = sel_mask;
          done_clr = sel_mask;
          ch_nxt = first_ch[CH_IDX_W-1:0];
          state_nxt = ST_EN_REQ;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // The run after reset is unlooped whatever the user drives; the first
  // accepted retune hands loopback back to the user
  always_comb
  begin
    boot_nxt = boot_r;
    if ((state_r == ST_TUNE_DONE) && retune_req && sel_legal)
    begin
      boot_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      boot_r <= 1'b1;
    end
    else
    begin
      boot_r <= boot_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky done bits; a set wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < CH_COUNT; gi++)
    begin : g_done
      assign done_nxt[gi] = done_set[gi] |
                            (done_r[gi] & ~done_clr[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous reset dominates, so channel_select is not looked at
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_START;
      mask_r <= MASK_ALL;
      ch_r <= '0;
      gap_r <= '0;
      done_r <= DONE_RST;
    end
    else
    begin
      state_r <= state_nxt;
      mask_r <= mask_nxt;
      ch_r <= ch_nxt;
      gap_r <= gap_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign tuning_done = done_r;
  assign tuning_state = state_r;
  assign status_read_channel = 4'({1'b0, ch_r});

endmodule : eqts_sequencer

`default_nettype wire

// ===== design/eqts_pkg.sv
// Constants shared by the equalizer tuning sequencer and its helpers.
// Assumes one sequencer per octal, on the configuration-port clock.
package eqts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Octal shape and channel selection
  localparam int CH_COUNT = 8;
  localparam int CH_IDX_W = 3;
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_ALL = 4'h8;
  localparam logic [3:0] SEL_NONE = 4'h8;
  localparam logic [7:0] MASK_ALL = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration port shape
  localparam int CFG_AW = 16;
  localparam int CFG_DW = 32;

  // Per-channel tuning control and status words, one stride per channel
  localparam logic [15:0] CTRL_BASE = 16'h0100;
  localparam logic [15:0] STAT_BASE = 16'h0104;
  localparam int CH_STRIDE_SHIFT = 4;

  // Control word fields
  localparam int EN_COARSE_BIT = 0;
  localparam int EN_FINE_BIT = 1;
  localparam int LOOPBACK_BIT = 2;
  localparam logic [31:0] CTRL_OFF = 32'h0000_0000;

  // Status word fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ERR_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int POLL_GAP_NS = 1000;
  // A least spacing, so round up
  localparam int POLL_GAP_CYC =
    (POLL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_CNT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] DONE_RST = 8'h00;
  localparam logic [3:0] DBG_CH_RST = 4'h0;

endpackage : eqts_pkg

// ===== design/eqts_chan_decode.sv
// Turns the channel selection code into a channel mask.
// Assumes the code is steady in the cycle it is sampled.
`timescale 1ns/1ns
`default_nettype none

module eqts_chan_decode
  import eqts_pkg::*;
(
  input wire logic [SEL_W-1:0] sel,
  output logic [CH_COUNT-1:0] mask,
  output logic legal
);

  ////////////////////////////////////////////////////////////////////////////
  // One mask bit per channel
  genvar gi;
  generate
    for (gi = 0; gi < CH_COUNT; gi++)
    begin : g_bit
      assign mask[gi] = (sel == SEL_ALL) ||
                        (sel == SEL_W'(gi));
    end
  endgenerate

  // Codes above all-channels select nothing and are refused
  assign legal = (sel <= SEL_ALL);

endmodule : eqts_chan_decode

`default_nettype wire

// ===== design/eqts_cfg_access.sv
// Single-access master for the dynamic configuration port.
// Assumes the port answers each enable with exactly one ready.
`timescale 1ns/1ns
`default_nettype none

module eqts_cfg_access
  import eqts_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_we,
  input wire logic [CFG_AW-1:0] req_addr,
  input wire logic [CFG_DW-1:0] req_wdata,
  output logic rsp_valid,
  output logic [CFG_DW-1:0] rsp_rdata,
  output logic cfg_en,
  output logic cfg_we,
  output logic [CFG_AW-1:0] cfg_addr,
  output logic [CFG_DW-1:0] cfg_wdata,
  input wire logic [CFG_DW-1:0] cfg_rdata,
  input wire logic cfg_ready
);

  typedef enum logic {ACC_IDLE, ACC_WAIT} eqts_acc_t;

  eqts_acc_t st_r, st_nxt;
  logic en_r, en_nxt;
  logic we_r, we_nxt;
  logic [CFG_AW-1:0] addr_r, addr_nxt;
  logic [CFG_DW-1:0] wdata_r, wdata_nxt;
  logic vld_r, vld_nxt;
  logic [CFG_DW-1:0] rdata_r, rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    en_nxt = 1'b0;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    vld_nxt = 1'b0;
    rdata_nxt = rdata_r;
    unique case (st_r)
      ACC_IDLE:
      begin
        // Requests while an access is open are dropped; caller waits
        if (req_valid)
        begin
          en_nxt = 1'b1;
          we_nxt = req_we;
          addr_nxt = req_addr;
          wdata_nxt = req_wdata;
          st_nxt = ACC_WAIT;
        end
      end
      ACC_WAIT:
      begin
        if (cfg_ready)
        begin
          vld_nxt = 1'b1;
          rdata_nxt = cfg_rdata;
          st_nxt = ACC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= ACC_IDLE;
      en_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      vld_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      en_r <= en_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      vld_r <= vld_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign cfg_en = en_r;
  assign cfg_we = we_r;
  assign cfg_addr = addr_r;
  assign cfg_wdata = wdata_r;
  assign rsp_valid = vld_r;
  assign rsp_rdata = rdata_r;

endmodule : eqts_cfg_access

`default_nettype wire

// ===== testbench/eqts_sequencer_monitor.sv
// Port checker for the equalizer tuning sequencer.
// Assumes it is bound to eqts_sequencer and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module eqts_sequencer_monitor
  import eqts_pkg::*;
#(
  parameter int POLL_CYC = POLL_GAP_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [CH_COUNT-1:0] loopback_en,
  input wire logic [SEL_W-1:0] channel_select,
  input wire logic retune_req,
  input wire logic [CH_COUNT-1:0] tuning_done,
  input wire logic [8:0] tuning_state,
  input wire logic [3:0] status_read_channel,
  input wire logic [CFG_AW-1:0] cfg_addr,
  input wire logic [CFG_DW-1:0] cfg_wdata,
  input wire logic cfg_en,
  input wire logic cfg_we,
  input wire logic [CFG_DW-1:0] cfg_rdata,
  input wire logic cfg_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  logic pend_r;
  logic pend_nxt;
  logic go;
  logic [7:0] sel_mask;
  assign go = tuning_state == 9'h8 && retune_req && channel_select <= SEL_ALL;
  assign sel_mask = (channel_select == SEL_ALL) ? MASK_ALL :
    8'h01 << channel_select[2:0];
  // Ready clears first so a stray ready cannot hide a new access
  always_comb
  begin
    pend_nxt = cfg_ready ? 1'b0 : pend_r;
    if (cfg_en)
      pend_nxt = 1'b1;
  end
  always_ff @(posedge clk)
    pend_r <= rst ? 1'b0 : pend_nxt;
  // Reset run is unlooped until the first accepted retune
  logic boot_r;
  always_ff @(posedge clk)
    boot_r <= rst ? 1'b1 : (go ? 1'b0 : boot_r);
  ////////////////////////////////////////////////////////////////////////////
  en_pulse_a: assert property (cfg_en |=> !cfg_en)
    else $error("config enable held too long");
  one_access_a: assert property (cfg_en |-> !pend_r)
    else $error("config access before ready");
  ready_gap_a: assert property (cfg_ready |=> !cfg_en)
    else $error("config access right after ready");
  reset_init_a: assert property (disable iff (1'b0) rst |=>
    tuning_state == 9'h0 && tuning_done == DONE_RST && !cfg_en)
    else $error("reset state wrong");
  start_run_a: assert property ($past(rst) && !rst |=>
    tuning_state == 9'h1) else $error("no run after reset");
  halt_done_a: assert property (tuning_state == 9'h8 && !go |=>
    tuning_state == 9'h8) else $error("left done without retune");
  retune_go_a: assert property (go |=> tuning_state == 9'h1 &&
    (tuning_done & $past(sel_mask)) == 8'h00)
    else $error("retune not started");
  read_chan_a: assert property (go |=>
    status_read_channel == $past(channel_select & 4'h7))
    else $error("status channel wrong on retune");
  ctrl_word_a: assert property (cfg_en && cfg_we &&
    cfg_wdata != CTRL_OFF |-> cfg_wdata[2:0] ==
    {loopback_en[status_read_channel[2:0]] & ~boot_r, 2'b11} &&
    cfg_addr == CTRL_BASE + {status_read_channel, 4'h0})
    else $error("control word wrong");
  stat_addr_a: assert property (cfg_en && !cfg_we |->
    cfg_addr == STAT_BASE + {status_read_channel, 4'h0})
    else $error("status address wrong");
  sticky_done_a: assert property (!go |=>
    (tuning_done & $past(tuning_done)) == $past(tuning_done))
    else $error("done bit dropped");
  state_code_a: assert property (tuning_state <= 9'h8)
    else $error("state code out of range");
  cover property (go && channel_select == SEL_ALL);
  cover property (go && channel_select < SEL_ALL && loopback_en != 8'h00);
  cover property (cfg_ready && !cfg_we && cfg_rdata[1:0] == 2'b11);
  cover property (cfg_en ##1 !cfg_ready [*3]);
  cover property (boot_r && cfg_en && cfg_we && loopback_en != 8'h00);
endmodule : eqts_sequencer_monitor
`default_nettype wire

// ===== testbench/eqts_cfg_model.sv
// Configuration-port model of the octal for the sequencer bench.
// Assumes one access at a time; status shows done on the third read.
`timescale 1ns/1ns
`default_nettype none
module eqts_cfg_model
  import eqts_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [CFG_AW-1:0] cfg_addr,
  input wire logic cfg_en,
  input wire logic cfg_we,
  input wire logic slow,
  input wire logic [7:0] err_mask,
  output var logic [CFG_DW-1:0] cfg_rdata = 32'h0,
  output var logic cfg_ready = 1'b0
);
  logic [1:0] polls [CH_COUNT];
  logic busy = 1'b0;
  logic we;
  logic [2:0] ch;
  int wait_n;
  always @(posedge clk)
  begin
    cfg_ready <= 1'b0;
    // Data only means something with ready, so it keeps moving
    cfg_rdata <= ~cfg_rdata;
    if (rst)
    begin
      busy <= 1'b0;
      for (int i = 0; i < CH_COUNT; i++)
        polls[i] <= 2'h0;
    end
    else if (cfg_en)
    begin
      busy <= 1'b1;
      we <= cfg_we;
      ch <= cfg_addr[6:4];
      wait_n <= slow ? 4 : 0;
    end
    else if (busy && wait_n > 0)
      wait_n <= wait_n - 1;
    else if (busy)
    begin
      busy <= 1'b0;
      cfg_ready <= 1'b1;
      if (we)
        polls[ch] <= 2'h0;
      else
      begin
        cfg_rdata <= {30'h0, err_mask[ch], polls[ch] == 2'h2};
        if (polls[ch] != 2'h2)
          polls[ch] <= polls[ch] + 2'h1;
      end
    end
  end
endmodule : eqts_cfg_model
`default_nettype wire

// ===== testbench/eqts_sequencer_tb.sv
// Self-checking bench for the equalizer tuning sequencer.
// Assumes the port model answers every access it is given.
`timescale 1ns/1ns
`default_nettype none
module eqts_sequencer_tb
  import eqts_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] loopback_en = 8'h00;
  logic [3:0] channel_select = 4'h0;
  logic retune_req = 1'b0;
  logic slow = 1'b0;
  logic [7:0] err_mask = 8'h00;
  logic [7:0] tuning_done;
  logic [8:0] tuning_state;
  logic [3:0] status_read_channel;
  logic [15:0] cfg_addr;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic cfg_en;
  logic cfg_we;
  logic cfg_ready;
  logic [7:0] exp_done = 8'h00;
  logic [7:0] exp_q [$];
  logic [8:0] prev_state = 9'h0;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] done_seen = 8'h00;
  logic [7:0] rx_fifo_reset = 8'h00;
  int fifo_pulses = 0;
  always #25 clk = ~clk;
  // Short poll gap keeps runs brief
  eqts_sequencer #(.POLL_CYC(4)) i_dut (.clk(clk), .rst(rst),
    .loopback_en(loopback_en), .channel_select(channel_select),
    .retune_req(retune_req), .tuning_done(tuning_done),
    .tuning_state(tuning_state), .status_read_channel(status_read_channel),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_en(cfg_en),
    .cfg_we(cfg_we), .cfg_rdata(cfg_rdata), .cfg_ready(cfg_ready));
  eqts_cfg_model i_port (.clk(clk), .rst(rst), .cfg_addr(cfg_addr),
    .cfg_en(cfg_en), .cfg_we(cfg_we), .slow(slow), .err_mask(err_mask),
    .cfg_rdata(cfg_rdata), .cfg_ready(cfg_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic step();
    @(posedge clk);
    #5;
  endtask : step
  task automatic wait_idle();
    for (int i = 0; i < 3000 && tuning_state !== 9'h8; i++)
      step();
  endtask : wait_idle
  task automatic run(input logic [3:0] s, input logic [7:0] l);
    logic [7:0] m;
    m = (s == SEL_ALL) ? MASK_ALL : 8'h01 << s[2:0];
    wait_idle();
    loopback_en = l; // Held steady for the whole run
    channel_select = s;
    retune_req = 1'b1;
    exp_done = (exp_done & ~m) | (m & ~err_mask);
    exp_q.push_back(exp_done);
    step();
    retune_req = 1'b0;
    step();
    wait_idle();
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (!rst && tuning_state === 9'h8 && prev_state !== 9'h8)
    begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected finish");
      else
        check(tuning_done === exp_q.pop_front(), "done vector");
    end
    prev_state <= rst ? 9'h0 : tuning_state;
  end
  // Stands in for the user's FIFO reset, one pulse per cleanly finished channel
  always @(posedge clk)
  begin
    rx_fifo_reset <= tuning_done & ~done_seen;
    done_seen <= tuning_done;
    if (rx_fifo_reset != 8'h00)
      fifo_pulses++;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  initial
  begin
    void'($urandom(32'hcf077c8e));
    channel_select = 4'hf; // Ignored while held in reset
    exp_done = MASK_ALL;
    exp_q.push_back(exp_done);
    repeat (2) step();
    check(tuning_done === DONE_RST && status_read_channel === DBG_CH_RST,
      "reset values");
    rst = 1'b0; // Receivers taken as ready here
    step();
    wait_idle();
    $display("test reset run done");
    slow = 1'b1;
    run(4'h3, 8'h08);
    slow = 1'b0;
    $display("test loopback retune done");
    err_mask = 8'h20;
    run(4'h5, 8'h00);
    run(SEL_ALL, 8'h00);
    err_mask = 8'h00;
    $display("test error finish done");
    channel_select = 4'h9;
    retune_req = 1'b1;
    step();
    retune_req = 1'b0;
    repeat (3) step();
    check(tuning_state === 9'h8 && tuning_done === exp_done,
      "illegal select");
    $display("test illegal select done");
    for (int i = 0; i < 10; i++)
    begin
      slow = 1'($urandom);
      run(4'($urandom_range(8)), 8'($urandom));
    end
    $display("test random retunes done");
    channel_select = SEL_ALL;
    retune_req = 1'b1;
    step();
    retune_req = 1'b0;
    repeat (30) step();
    rst = 1'b1;
    loopback_en = 8'($urandom); // Reset run must stay unlooped
    channel_select = 4'($urandom);
    repeat (2) step();
    rst = 1'b0;
    exp_done = MASK_ALL;
    exp_q.push_back(exp_done);
    step();
    wait_idle();
    $display("test reset mid-run done");
    check(fifo_pulses > 0, "no fifo reset pulse");
    results();
  end
endmodule : eqts_sequencer_tb
bind eqts_sequencer eqts_sequencer_monitor #(.POLL_CYC(POLL_CYC)) i_mon (
  .clk(clk), .rst(rst), .loopback_en(loopback_en),
  .channel_select(channel_select), .retune_req(retune_req),
  .tuning_done(tuning_done), .tuning_state(tuning_state),
  .status_read_channel(status_read_channel), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_en(cfg_en), .cfg_we(cfg_we),
  .cfg_rdata(cfg_rdata), .cfg_ready(cfg_ready));
`default_nettype wire
